// ### rtl/cpi_pkg.sv
// Shared constants, types and frame helpers for the card power-up link.
// Assumes a host end on sys_clk and a card end clocked by the link clock.
// Contract
// - Card enters idle after every power-up.
// - Idle card ignores all but voltage negotiation.
// - Negotiation reply carries voltage profile and busy.
// - Shared busy stays low while any card busy.
// - Host repeats negotiation until busy clears.
// - Host negotiates only once supply is good.
// - Host holds command high before any command.
// - Ones run: longest of 1 ms, 74 clocks, ramp.
// - Card listens after 64 clocks of ones.
// - Identification clock at most 400 kHz.
// - Transfer clock at most 20 MHz.
// - Card keeps host-assigned address, answers it.
// - No driver stage register; its command ignored.
// - Reply bit 31 low busy, high ready.
package cpi_pkg;

  // System clock period in nanoseconds.
  localparam int SYS_CLK_NS = 10;
  // Least length of the ones run in nanoseconds, and in sys_clk cycles.
  localparam int INIT_MS_NS = 1000000;
  localparam int INIT_MS_CYC = (INIT_MS_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  // Least length of the ones run in link clocks.
  localparam int INIT_ONES_CLKS = 74;
  // Link clocks of ones after which the card starts to listen.
  localparam int CARD_LISTEN_CLKS = 64;
  // Highest link clock rates, and the least half period in sys_clk cycles.
  localparam int OD_FMAX_KHZ = 400;
  localparam int PP_FMAX_MHZ = 20;
  localparam int OD_PERIOD_NS = 1000000 / OD_FMAX_KHZ;
  localparam int PP_PERIOD_NS = 1000 / PP_FMAX_MHZ;
  localparam int OD_HALF_CYC = (OD_PERIOD_NS + 2 * SYS_CLK_NS - 1) /
                               (2 * SYS_CLK_NS);
  localparam int PP_HALF_CYC = (PP_PERIOD_NS + 2 * SYS_CLK_NS - 1) /
                               (2 * SYS_CLK_NS);
  // Frame layout: start, direction, index, argument, check, end.
  localparam int FRAME_W = 48;
  localparam int REL_ADDR_W = 16;
  localparam int VOLT_BUSY_BIT = 31;
  // Link clocks from a command end to the reply start at the card.
  localparam int NCR_CLKS = 2;
  // Link clocks the host waits for a reply start before retrying.
  localparam int NCR_MAX = 64;
  // Link clocks of ones the host leaves between two commands.
  localparam int NCC_CLKS = 8;
  // Link clocks the card needs to finish its internal power-up.
  localparam int CARD_PWRUP_CLKS = 200;
  // Command indices.
  localparam logic [5:0] IDX_GO_IDLE = 6'h00;
  localparam logic [5:0] IDX_OP_COND = 6'h01;
  localparam logic [5:0] IDX_SET_ADDR = 6'h03;
  localparam logic [5:0] IDX_SET_DSR = 6'h04;
  // Voltage profile: the 2.7 V to 3.6 V windows.
  localparam logic [31:0] VOLT_PROFILE = 32'h00ff8000;
  // Address the host hands out by default.
  localparam logic [15:0] HOST_ADDR_DEF = 16'h0001;

  // Card protocol mode.
  typedef enum logic [2:0] {
    CM_IDLE = 3'b001, CM_READY = 3'b010, CM_STBY = 3'b100
  } cpi_mode_t;
  // Card link phase.
  typedef enum logic [4:0] {
    CP_WARM = 5'b00001, CP_LISTEN = 5'b00010, CP_RECV = 5'b00100,
    CP_TURN = 5'b01000, CP_SEND = 5'b10000
  } cpi_phase_t;
  // Host sequence state.
  typedef enum logic [5:0] {
    HS_PRE = 6'b000001, HS_SEND = 6'b000010, HS_WAIT = 6'b000100,
    HS_RECV = 6'b001000, HS_GAP = 6'b010000, HS_DONE = 6'b100000
  } cpi_hstate_t;

  // Card state.
  typedef struct packed {
    cpi_mode_t mode; cpi_phase_t ph; logic [6:0] warm; logic [5:0] cnt;
    logic [15:0] busy; logic started; logic done; logic [47:0] sh;
    logic [15:0] relative_card_address; logic out; logic oe;
  } cpi_card_st_t;
  localparam cpi_card_st_t CARD_RST = '{mode: CM_IDLE, ph: CP_WARM,
    warm: 7'h00, cnt: 6'h00, busy: 16'h0000, started: 1'b0, done: 1'b0,
    sh: 48'h0, relative_card_address: 16'h0000, out: 1'b1, oe: 1'b0};

  // Host state.
  typedef struct packed {
    cpi_hstate_t st; logic lclk; logic [7:0] div; logic pp;
    logic [16:0] ms; logic [6:0] pre; logic [6:0] cnt; logic [47:0] sh;
    logic cmd3; logic [31:0] operating_voltage_register;
    logic out; logic oe; logic done;
  } cpi_host_st_t;
  localparam cpi_host_st_t HOST_RST = '{st: HS_PRE, lclk: 1'b0,
    div: 8'h00, pp: 1'b0, ms: 17'h00000, pre: 7'h00, cnt: 7'h00,
    sh: 48'h0, cmd3: 1'b0, operating_voltage_register: 32'h0,
    out: 1'b1, oe: 1'b0, done: 1'b0};

  // Seven-bit check over the first 40 frame bits, polynomial x7+x3+1.
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

  // Builds one frame; dir is high for host to card.
  function automatic logic [47:0] mk_frame(input logic [5:0] idx,
                                           input logic [31:0] arg,
                                           input logic dir);
    logic [39:0] head;
    head = {1'b0, dir, idx, arg};
    return {head, crc7(head), 1'b1};
  endfunction

endpackage

// ### rtl/cpi_link_if.sv
// Shared command link between the host end and the card end.
// Assumes a pull-up: the line is low only where a driver pulls it low.
`timescale 1ns/1ns
interface cpi_link_if;
  // Link clock, made by the host.
  logic clk;
  // Host drive value and enable.
  logic h_out;
  logic h_oe;
  // Card drive value and enable.
  logic c_out;
  logic c_oe;
  // Resolved command line, wired-AND of the drivers.
  logic cmd;

  // Any enabled driver showing zero pulls the line low.
  assign cmd = ~((h_oe & ~h_out) | (c_oe & ~c_out));

  modport host (output clk, output h_out, output h_oe, input cmd);
  modport card (input clk, input cmd, output c_out, output c_oe);
endinterface

// ### rtl/cpi_sync2.sv
// Two-flop synchroniser for levels entering a clock domain.
// Assumes the inputs change slowly compared with the clock.
`timescale 1ns/1ns
module cpi_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Both stages in one state word; only the second stage is read.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cpi_sync_st_t;

  cpi_sync_st_t st_ff;
  cpi_sync_st_t nxt_st;

  // Shifts the input through the two stages.
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  // Registers the stages; reset shows all ones, the idle line level.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule

// ### rtl/cpi_card.sv
// Card end of the command link: power-up, negotiation and addressing.
// Assumes the host makes the link clock and keeps its own sequence.
`timescale 1ns/1ns
module cpi_card #(
  parameter int PWRUP_CLKS = cpi_pkg::CARD_PWRUP_CLKS
) (
  input wire logic nrst,
  cpi_link_if.card link,
  output logic card_ready,
  output logic card_idle,
  output logic [cpi_pkg::REL_ADDR_W-1:0] relative_card_address
);
  import cpi_pkg::*;

  // Registered card state and its next value.
  cpi_card_st_t st_ff;
  cpi_card_st_t nxt_st;
  // Command line after the two synchronising stages.
  logic line_sync;

  // The line passes two flops on the link clock before any logic reads it.
  cpi_sync2 #(
    .W(1)
  ) u_sync (
    .clk(link.clk),
    .nrst(nrst),
    .d(link.cmd),
    .q(line_sync)
  );

  // Works out the next card state for every link clock.
  always_comb begin
    logic [47:0] f;
    logic ok;
    logic [5:0] idx;
    logic [31:0] arg;
    logic [31:0] stat;
    nxt_st = st_ff;
    // The frame as it stands once the current bit is shifted in.
    f = {st_ff.sh[46:0], line_sync};
    // A frame counts only with a host direction bit, end bit and check.
    ok = f[46] & f[0] & (crc7(f[47:8]) == f[7:1]);
    idx = f[45:40];
    arg = f[39:8];
    // The status word reports the present mode in its low bits.
    stat = {29'h0, st_ff.mode};
    // The line is released unless a reply bit is being sent.
    nxt_st.out = 1'b1;
    nxt_st.oe = 1'b0;

    // The internal power-up runs from the first negotiation to its end.
    if (st_ff.started && !st_ff.done) begin
      nxt_st.busy = st_ff.busy + 16'h0001;
      if (st_ff.busy == 16'(PWRUP_CLKS - 1)) begin
        nxt_st.done = 1'b1;
      end
    end

    unique case (st_ff.ph)
      // Counts the first clocks of the ones run without listening.
      CP_WARM: begin
        nxt_st.warm = st_ff.warm + 7'h01;
        if (st_ff.warm == 7'(CARD_LISTEN_CLKS - 1)) begin
          nxt_st.ph = CP_LISTEN;
        end
      end
      // Waits for a start bit; ones are passed over silently.
      CP_LISTEN: begin
        if (!line_sync) begin
          nxt_st.ph = CP_RECV;
          nxt_st.sh = f;
          nxt_st.cnt = 6'h01;
        end
      end
      // Collects the rest of the frame and decides on it.
      CP_RECV: begin
        nxt_st.sh = f;
        nxt_st.cnt = st_ff.cnt + 6'h01;
        if (st_ff.cnt == 6'(FRAME_W - 1)) begin
          nxt_st.ph = CP_LISTEN;
          nxt_st.cnt = 6'h00;
          if (ok) begin
            unique case (st_ff.mode)
              // Idle answers only the negotiation command.
              CM_IDLE: begin
                if (idx == IDX_OP_COND) begin
                  nxt_st.started = 1'b1;
                  // Reply: profile plus busy bit, low while busy.
                  nxt_st.sh = {2'b00, 6'h3f, st_ff.done,
                               VOLT_PROFILE[30:0], 7'h7f,
                               1'b1};
                  nxt_st.ph = CP_TURN;
                  if (st_ff.done) begin
                    nxt_st.mode = CM_READY;
                  end
                end
              end
              // Ready takes its session address or a return to idle.
              CM_READY: begin
                if (idx == IDX_SET_ADDR) begin
                  nxt_st.relative_card_address = arg[31:16];
                  nxt_st.mode = CM_STBY;
                  nxt_st.sh = mk_frame(idx, stat, 1'b0);
                  nxt_st.ph = CP_TURN;
                end else if (idx == IDX_GO_IDLE) begin
                  nxt_st.mode = CM_IDLE;
                end
              end
              // Standby answers only frames carrying its own address.
              CM_STBY: begin
                if (idx == IDX_GO_IDLE) begin
                  nxt_st.mode = CM_IDLE;
                end else if (idx == IDX_SET_DSR) begin
                  // The driver stage cannot be set; no reply.
                  nxt_st.mode = st_ff.mode;
                end else if (arg[31:16] == st_ff.relative_card_address) begin
                  nxt_st.sh = mk_frame(idx, stat, 1'b0);
                  nxt_st.ph = CP_TURN;
                end
              end
            endcase
          end
        end
      end
      // Waits the turnaround, then puts out the first reply bit.
      CP_TURN: begin
        nxt_st.cnt = st_ff.cnt + 6'h01;
        if (st_ff.cnt == 6'(NCR_CLKS - 1)) begin
          nxt_st.ph = CP_SEND;
          nxt_st.out = st_ff.sh[47];
          nxt_st.oe = ~st_ff.sh[47];
          nxt_st.sh = {st_ff.sh[46:0], 1'b1};
          nxt_st.cnt = 6'h01;
        end
      end
      // Sends the reply open drain: only zeros are driven, so any
      // busy card holds the shared busy bit low.
      CP_SEND: begin
        if (st_ff.cnt == 6'(FRAME_W)) begin
          nxt_st.ph = CP_LISTEN;
          nxt_st.cnt = 6'h00;
        end else begin
          nxt_st.out = st_ff.sh[47];
          nxt_st.oe = ~st_ff.sh[47];
          nxt_st.sh = {st_ff.sh[46:0], 1'b1};
          nxt_st.cnt = st_ff.cnt + 6'h01;
        end
      end
    endcase
  end

  // Registers the state; every power-up lands in idle, line released.
  always_ff @(posedge link.clk) begin
    if (!nrst) begin
      st_ff <= CARD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Line drive comes straight from the state register.
  assign link.c_out = st_ff.out;
  assign link.c_oe = st_ff.oe;
  // User-side status, each a field of the state register.
  assign card_ready = st_ff.done;
  assign card_idle = st_ff.mode[0];
  assign relative_card_address = st_ff.relative_card_address;
endmodule

// ### rtl/cpi_host.sv
// Host end of the command link: clock, ones run and polling sequence.
// Assumes supply_ok is an asynchronous level from the power monitor.
`timescale 1ns/1ns
module cpi_host #(
  parameter int MS_CYC = cpi_pkg::INIT_MS_CYC,
  parameter int OD_HALF = cpi_pkg::OD_HALF_CYC,
  parameter int PP_HALF = cpi_pkg::PP_HALF_CYC,
  parameter logic [15:0] HOST_ADDR = cpi_pkg::HOST_ADDR_DEF,
  parameter logic [31:0] VOLT_ARG = cpi_pkg::VOLT_PROFILE
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic supply_ok,
  cpi_link_if.host link,
  output logic host_done,
  output logic host_pp,
  output logic [31:0] operating_voltage_register
);
  import cpi_pkg::*;

  // Registered host state and its next value.
  cpi_host_st_t st_ff;
  cpi_host_st_t nxt_st;
  // Synchronised supply level (bit 1) and command line (bit 0).
  logic [1:0] in_sync;

  // Both outside levels pass two flops before use.
  cpi_sync2 #(
    .W(2)
  ) u_sync (
    .clk(sys_clk),
    .nrst(nrst),
    .d({supply_ok, link.cmd}),
    .q(in_sync)
  );

  // Divides the clock, and at each falling link edge samples and drives.
  always_comb begin
    logic [7:0] half;
    logic tick;
    logic line;
    logic [47:0] f;
    nxt_st = st_ff;
    // Slow clock while identifying, fast once in transfer mode.
    half = st_ff.pp ? 8'(PP_HALF) : 8'(OD_HALF);
    tick = st_ff.lclk && (st_ff.div == half - 8'h01);
    line = in_sync[0];
    f = {st_ff.sh[46:0], line};
    nxt_st.div = st_ff.div + 8'h01;
    if (st_ff.div == half - 8'h01) begin
      nxt_st.div = 8'h00;
      nxt_st.lclk = ~st_ff.lclk;
    end
    // Measures the least run time in sys_clk cycles.
    if (st_ff.ms != 17'(MS_CYC)) begin
      nxt_st.ms = st_ff.ms + 17'h00001;
    end
    if (tick) begin
      nxt_st.out = 1'b1;
      nxt_st.oe = 1'b0;
      unique case (st_ff.st)
        // Line left high until all three run lengths are met.
        HS_PRE: begin
          if (st_ff.pre != 7'(INIT_ONES_CLKS)) begin
            nxt_st.pre = st_ff.pre + 7'h01;
          end
          if (st_ff.pre == 7'(INIT_ONES_CLKS) &&
              st_ff.ms == 17'(MS_CYC) && in_sync[1]) begin
            nxt_st.st = HS_SEND;
            nxt_st.sh = mk_frame(IDX_OP_COND, VOLT_ARG, 1'b1);
            nxt_st.cnt = 7'h00;
          end
        end
        // Shifts the command out, zeros driven, ones left to pull-up.
        HS_SEND: begin
          nxt_st.out = st_ff.sh[47];
          nxt_st.oe = ~st_ff.sh[47];
          nxt_st.sh = {st_ff.sh[46:0], 1'b1};
          nxt_st.cnt = st_ff.cnt + 7'h01;
          if (st_ff.cnt == 7'(FRAME_W - 1)) begin
            nxt_st.st = HS_WAIT;
            nxt_st.cnt = 7'h00;
          end
        end
        // Waits for a reply start; a silent card is polled again.
        HS_WAIT: begin
          nxt_st.cnt = st_ff.cnt + 7'h01;
          if (!line) begin
            nxt_st.st = HS_RECV;
            nxt_st.sh = f;
            nxt_st.cnt = 7'h01;
          end else if (st_ff.cnt == 7'(NCR_MAX - 1)) begin
            nxt_st.st = HS_GAP;
            nxt_st.cnt = 7'h00;
          end
        end
        // Collects the reply and chooses the next command.
        HS_RECV: begin
          nxt_st.sh = f;
          nxt_st.cnt = st_ff.cnt + 7'h01;
          if (st_ff.cnt == 7'(FRAME_W - 1)) begin
            nxt_st.st = HS_GAP;
            nxt_st.cnt = 7'h00;
            if (st_ff.cmd3) begin
              nxt_st.st = HS_DONE;
              nxt_st.pp = 1'b1;
              nxt_st.done = 1'b1;
            end else begin
              nxt_st.operating_voltage_register = f[39:8];
              // Busy bit still low: poll again after the gap.
              nxt_st.cmd3 = f[8 + VOLT_BUSY_BIT];
            end
          end
        end
        // Leaves ones between commands, then starts the next one.
        HS_GAP: begin
          nxt_st.cnt = st_ff.cnt + 7'h01;
          if (st_ff.cnt == 7'(NCC_CLKS - 1)) begin
            nxt_st.st = HS_SEND;
            nxt_st.cnt = 7'h00;
            nxt_st.sh = st_ff.cmd3 ?
                        mk_frame(IDX_SET_ADDR, {HOST_ADDR, 16'h0000}, 1'b1) :
                        mk_frame(IDX_OP_COND, VOLT_ARG, 1'b1);
          end
        end
        // Sequence finished; line idle.
        HS_DONE: begin
          nxt_st.st = HS_DONE;
        end
      endcase
    end
  end

  // Registers the host state.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff <= HOST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Link pins and status come straight from the state register.
  assign link.clk = st_ff.lclk;
  assign link.h_out = st_ff.out;
  assign link.h_oe = st_ff.oe;
  assign host_done = st_ff.done;
  assign host_pp = st_ff.pp;
  assign operating_voltage_register = st_ff.operating_voltage_register;
endmodule

// ### verif/cpi_link_monitor.sv
// Checker for the link that joins the host end and the card end.
// Assumes the bench hands it the link signals, both resets and host_pp.
`timescale 1ns/1ns
module cpi_link_monitor #(
  parameter int MS_CYC = 200,
  parameter int OD_HALF = 8,
  parameter int PP_HALF = 3
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic card_nrst,
  input wire logic supply_ok,
  input wire logic host_pp,
  input wire logic clk,
  input wire logic h_out,
  input wire logic h_oe,
  input wire logic c_out,
  input wire logic c_oe,
  input wire logic cmd
);
  // Link clock one cycle late, to spot its edges on sys_clk.
  logic clk_d;
  // Set once the host has pulled the line for the first time.
  logic started;
  // Set after the first link clock edge, which has no full half period.
  logic tog_seen;
  // Link rises with the line high, and sys cycles since the last edge.
  logic [7:0] ones_cnt;
  logic [7:0] hcnt;
  // Sys cycles since reset release, saturating.
  logic [16:0] sys_cnt;
  wire tog = clk != clk_d;
  // Card out of reset and ones run under way; before that c_oe is unknown.
  wire pre = card_nrst && ones_cnt != 8'h00 && !started;

  // Counters that measure the ones run and the link clock half periods.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      clk_d <= 1'b0;
      started <= 1'b0;
      tog_seen <= 1'b0;
      ones_cnt <= 8'h00;
      hcnt <= 8'h00;
      sys_cnt <= 17'h00000;
    end else begin
      clk_d <= clk;
      started <= started | h_oe;
      tog_seen <= tog_seen | tog;
      hcnt <= tog ? 8'h00 : hcnt + {7'h00, hcnt != 8'hff};
      sys_cnt <= sys_cnt + {16'h0000, sys_cnt != 17'h1ffff};
      if (tog && clk && cmd) begin
        ones_cnt <= ones_cnt + {7'h00, ones_cnt != 8'hff};
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // The first pull of the line by the host ends the ones run.
  sequence s_first_cmd;
    !started && $rose(h_oe);
  endsequence
  property p_ones_run;
    s_first_cmd |-> ones_cnt >= 74;
  endproperty
  a_ones_run: assert property (p_ones_run)
    else $error("ones run shorter than 74 link clocks");
  property p_ms_run;
    s_first_cmd |-> sys_cnt >= MS_CYC;
  endproperty
  a_ms_run: assert property (p_ms_run)
    else $error("ones run shorter than the time limit");
  property p_supply;
    s_first_cmd |-> supply_ok && $past(supply_ok, 2);
  endproperty
  a_supply: assert property (p_supply)
    else $error("first command before supply good");
  property p_ones_high;
    pre && !h_oe |-> cmd;
  endproperty
  a_ones_high: assert property (p_ones_high)
    else $error("line low during ones run");
  property p_card_silent;
    pre |-> !c_oe;
  endproperty
  a_card_silent: assert property (p_card_silent)
    else $error("card drives during ones run");
  property p_wired;
    (c_oe && !c_out) || (h_oe && !h_out) |-> !cmd;
  endproperty
  a_wired: assert property (p_wired)
    else $error("a pulled line reads high");
  property p_no_clash;
    c_oe |-> !h_oe;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("host and card drive together");
  property p_od_clk;
    tog && tog_seen && !host_pp |-> hcnt >= OD_HALF - 1;
  endproperty
  a_od_clk: assert property (p_od_clk)
    else $error("identification clock too fast");
  property p_pp_clk;
    tog && tog_seen |-> hcnt >= PP_HALF - 1;
  endproperty
  a_pp_clk: assert property (p_pp_clk)
    else $error("transfer clock too fast");
endmodule

// ### verif/tb.sv
// Bench: host and card on one link, plus a lone card driven by the bench.
// Assumes the package helpers and the interface's pull-up resolution.
`timescale 1ns/1ns
module tb;
  import cpi_pkg::*;
  logic sys_clk, nrst, card_nrst, supply_ok, nrst2, seen_busy, got;
  logic host_done, host_pp, card_ready, card_idle, card_ready2, card_idle2;
  logic [31:0] host_volt;
  logic [15:0] card_addr, card_addr2;
  logic [47:0] rsp;
  int err_total, comparisons, n;
  // Voltage replies: start, dir 0, index 6'h3f, word, check 7'h7f, end.
  localparam logic [47:0] BUSY_W = {8'h3f, 32'h00ff8000, 8'hff};
  localparam logic [47:0] READY_W = {8'h3f, 32'h80ff8000, 8'hff};

  cpi_link_if link();
  cpi_link_if link2();
  cpi_host #(.MS_CYC(200), .OD_HALF(8), .HOST_ADDR(16'h0005)) u_cpi_host (
    .sys_clk(sys_clk), .nrst(nrst), .supply_ok(supply_ok), .link(link),
    .host_done(host_done), .host_pp(host_pp),
    .operating_voltage_register(host_volt));
  cpi_card u_cpi_card (.nrst(card_nrst), .link(link),
    .card_ready(card_ready), .card_idle(card_idle),
    .relative_card_address(card_addr));
  // Second card, driven straight by the bench to send illegal commands.
  cpi_card u_cpi_card_2 (.nrst(nrst2), .link(link2),
    .card_ready(card_ready2), .card_idle(card_idle2),
    .relative_card_address(card_addr2));
  cpi_link_monitor #(.MS_CYC(200), .OD_HALF(8), .PP_HALF(PP_HALF_CYC))
    u_cpi_link_monitor (.sys_clk(sys_clk), .nrst(nrst),
    .card_nrst(card_nrst), .supply_ok(supply_ok), .host_pp(host_pp),
    .clk(link.clk), .h_out(link.h_out), .h_oe(link.h_oe),
    .c_out(link.c_out), .c_oe(link.c_oe), .cmd(link.cmd));

  // Compares one result and counts it.
  task automatic chk(input logic [47:0] g, input logic [47:0] e,
                     input string what);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  // One 15 ns link clock of the second link; it stops between calls.
  task automatic tick();
    #8 link2.clk = 1'b1;
    #7 link2.clk = 1'b0;
  endtask

  // Sends one frame open-drain, then waits for and collects a reply.
  task automatic xfer(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    f = mk_frame(idx, arg, 1'b1);
    got = 1'b0;
    rsp = 48'h0;
    for (int i = 47; i >= 0; i--) begin
      link2.h_oe = ~f[i];
      tick();
    end
    link2.h_oe = 1'b0;
    for (int i = 0; i < 64 && got !== 1'b1; i++) begin
      if (link2.cmd === 1'b0) got = 1'b1;
      else tick();
    end
    for (int i = 47; i >= 0 && got === 1'b1; i--) begin
      rsp[i] = link2.cmd;
      tick();
    end
    repeat (8) tick();
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Notes that the host received at least one busy reply.
  always @(posedge sys_clk) begin
    if (!nrst) seen_busy <= 1'b0;
    else if (host_volt === 32'h00ff8000) seen_busy <= 1'b1;
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    test_done();
  end

  // Main sequence: lone card first, then the host-card pair.
  initial begin
    nrst = 1'b0;
    card_nrst = 1'b0;
    supply_ok = 1'b0;
    nrst2 = 1'b0;
    err_total = 0;
    comparisons = 0;
    link2.clk = 1'b0;
    link2.h_out = 1'b0;
    link2.h_oe = 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (80) @(posedge sys_clk);
    card_nrst <= 1'b1;
    repeat (4) tick();
    nrst2 = 1'b1;
    chk(card_idle2, 1'b1, "card not idle after power-up");
    repeat (10) tick();
    xfer(IDX_OP_COND, VOLT_PROFILE);
    chk(got, 1'b0, "reply within the ones run");
    xfer(IDX_SET_ADDR, 32'h00a50000);
    chk(got, 1'b0, "idle card took an address");
    xfer(IDX_SET_DSR, 32'h00000000);
    chk(got, 1'b0, "idle card took a driver setting");
    xfer(IDX_OP_COND, VOLT_PROFILE);
    chk(rsp, BUSY_W, "busy voltage reply");
    chk(card_idle2, 1'b1, "left idle while busy");
    for (n = 0; n < 6 && rsp !== READY_W; n++) begin
      xfer(IDX_OP_COND, VOLT_PROFILE);
    end
    chk(rsp, READY_W, "ready voltage reply");
    chk({card_ready2, card_idle2}, 2'b10, "modes once ready");
    xfer(IDX_SET_ADDR, 32'h00a50000);
    chk(rsp[45:40], IDX_SET_ADDR, "address reply index");
    chk(card_addr2, 16'h00a5, "stored address");
    xfer(IDX_SET_DSR, 32'h00a50000);
    chk(got, 1'b0, "driver setting answered");
    @(posedge sys_clk);
    supply_ok <= 1'b1;
    for (n = 0; n < 20000 && host_done !== 1'b1; n++) @(posedge sys_clk);
    repeat (50) @(posedge sys_clk);
    #1;
    chk(host_done, 1'b1, "host sequence finished");
    chk(seen_busy, 1'b1, "host polled through busy");
    chk(host_volt, 32'h80ff8000, "host voltage word");
    chk(card_addr, 16'h0005, "assigned address");
    chk({card_ready, card_idle, host_pp}, 3'b101, "final modes");
    test_done();
  end
endmodule
